// [src/camera_serial_framer.v]
/*
 * Camera parallel to CSI-1 serial framer: samples the pixel port, embeds
 * line and frame codes, escapes code-like pixel data, serializes bytes.
 * Assumes the pixel port is asynchronous to clk and the pixel clock is at
 * most one sixteenth of clk; line blanking lasts at least eight pixels.
 */
`include "camera_framer_defs.vh"

module camera_serial_framer (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       pixel_clock_in,
    input  wire       frame_valid,
    input  wire       line_valid,
    input  wire [7:0] pixel_data,
    output wire       serial_clk,
    output wire       serial_data
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function [7:0] code_byte;
        input [7:0] code_type;
        input [1:0] index;
        begin
            case (index)
                2'h0:    code_byte = `CODE_LEAD_BYTE;
                2'h1:    code_byte = `CODE_ZERO_BYTE;
                2'h2:    code_byte = `CODE_ZERO_BYTE;
                default: code_byte = code_type;
            endcase
        end
    endfunction

    // Eight ones ending in the older or newer byte, then zeros to the end
    function needs_escape;
        input [7:0] older;
        input [7:0] newer;
        input [7:0] current;
        integer k;
        begin
            needs_escape = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (current == 8'h00 && newer == (8'hFF >> (8 - k)) &&
                    (older | (8'hFF >> (8 - k))) == 8'hFF)
                    needs_escape = 1'b1;
            end
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    reg [10:0] sync_a;
    reg [10:0] sync_b;
    reg        pclk_prev;

    always @(posedge clk) begin
        if (!rst_n) begin
            sync_a    <= 11'h000;
            sync_b    <= 11'h000;
            pclk_prev <= 1'b0;
        end else begin
            sync_a    <= {pixel_clock_in, frame_valid, line_valid, pixel_data};
            sync_b    <= sync_a;
            pclk_prev <= sync_b[10];
        end
    end

    wire       pclk_s = sync_b[10];
    wire       fv_s   = sync_b[9];
    wire       lv_s   = sync_b[8];
    wire [7:0] data_s = sync_b[7:0];
    // Falling pixel clock edge starts a byte slot
    wire       slot_tick = pclk_prev & ~pclk_s;

    // ****************************************************************
    // Framing
    // ****************************************************************
    reg        fv_prev;
    reg        lv_prev;
    reg        first_line_pending;
    reg        line_open;
    reg [7:0]  dly_byte [0:3];
    reg [3:0]  dly_valid;
    reg        code_active;
    reg [1:0]  code_index;
    reg [7:0]  code_type;
    reg [2:0]  end_wait;
    reg [7:0]  end_type;
    reg [7:0]  hist_older;
    reg [7:0]  hist_newer;
    reg [7:0]  tx_byte;

    wire line_rise = lv_s & ~lv_prev & fv_s;
    wire line_fall = ~lv_s & lv_prev & line_open;
    wire frame_fall = ~fv_s & fv_prev;
    // A frame rise together with a line rise still opens the frame
    wire frame_rise = fv_s & ~fv_prev;
    wire capture = fv_s & lv_s;
    wire end_now = (end_wait == 3'h1);

    reg [7:0] next_tx_byte;
    reg       next_code_active;
    reg [1:0] next_code_index;
    reg [7:0] next_code_type;
    reg       emit_pixel;

    always @* begin
        next_tx_byte     = `IDLE_BYTE;
        next_code_active = code_active;
        next_code_index  = code_index;
        next_code_type   = code_type;
        emit_pixel       = 1'b0;
        if (line_rise) begin
            // First line of a frame opens with the frame marker
            next_code_type = (first_line_pending | frame_rise) ? `FRAME_START_MARKER
                                                               : `LINE_START_CODE;
            next_tx_byte     = code_byte(next_code_type, 2'h0);
            next_code_active = 1'b1;
            next_code_index  = 2'h1;
        end else if (end_now) begin
            next_code_type   = end_type;
            next_tx_byte     = code_byte(end_type, 2'h0);
            next_code_active = 1'b1;
            next_code_index  = 2'h1;
        end else if (code_active) begin
            next_tx_byte     = code_byte(code_type, code_index);
            next_code_active = (code_index != 2'h3);
            next_code_index  = code_index + 2'h1;
        end else if (dly_valid[3]) begin
            emit_pixel = 1'b1;
            // Pixel bytes go through untouched except for escapes
            if (needs_escape(hist_older, hist_newer, dly_byte[3]))
                next_tx_byte = `ESCAPED_ZERO;
            else
                next_tx_byte = dly_byte[3];
        end
    end

    integer i;

    always @(posedge clk) begin
        if (!rst_n) begin
            fv_prev            <= 1'b0;
            lv_prev            <= 1'b0;
            first_line_pending <= 1'b0;
            dly_valid          <= 4'h0;
            code_active        <= 1'b0;
            code_index         <= 2'h0;
            code_type          <= `LINE_START_CODE;
            end_wait           <= 3'h0;
            end_type           <= `LINE_END_CODE;
            hist_older         <= 8'h00;
            hist_newer         <= 8'h00;
            tx_byte            <= `IDLE_BYTE;
            for (i = 0; i < 4; i = i + 1)
                dly_byte[i] <= 8'h00;
        end else if (slot_tick) begin
            fv_prev     <= fv_s;
            lv_prev     <= lv_s;
            tx_byte     <= next_tx_byte;
            code_active <= next_code_active;
            code_index  <= next_code_index;
            code_type   <= next_code_type;
            // Frame valid rise arms the frame marker for the next line
            if (frame_rise & ~line_rise)
                first_line_pending <= 1'b1;
            else if (line_rise)
                first_line_pending <= 1'b0;
            // Line end code waits for the delayed pixels to drain
            if (line_fall) begin
                end_wait <= `DATA_DELAY_SLOTS;
                end_type <= frame_fall ? `FRAME_END_MARKER
                                       : `LINE_END_CODE;
            end else if (end_wait != 3'h0) begin
                end_wait <= end_wait - 3'h1;
            end
            dly_byte[0]  <= data_s;
            dly_valid[0] <= capture;
            for (i = 1; i < 4; i = i + 1)
                dly_byte[i] <= dly_byte[i - 1];
            dly_valid[3:1] <= dly_valid[2:0];
            // Escape history restarts after each code
            if (emit_pixel) begin
                hist_older <= hist_newer;
                hist_newer <= next_tx_byte;
            end else if (next_code_active | line_rise | end_now) begin
                hist_older <= 8'h00;
                hist_newer <= 8'h00;
            end
        end
    end

    // ****************************************************************
    // Line tracking
    // ****************************************************************
    // Only a line opened inside a valid frame may be closed; a line-valid
    // pulse while frame valid is low leaves no end code behind
    always @(posedge clk) begin
        if (!rst_n) begin
            line_open <= 1'b0;
        end else if (slot_tick) begin
            if (line_rise)
                line_open <= 1'b1;
            else if (line_fall)
                line_open <= 1'b0;
        end
    end

    // ****************************************************************
    // Serializer, standard CSI-1 stream only
    // ****************************************************************
    serial_byte_tx u_tx (
        .clk         (clk),
        .rst_n       (rst_n),
        .slot_tick   (slot_tick),
        .load_byte   (tx_byte),
        .serial_clk  (serial_clk),
        .serial_data (serial_data)
    );

endmodule // camera_serial_framer

// [src/camera_framer_defs.vh]
/*
 * Constants of the camera serial framer: synchronisation codes, pipeline
 * depth, clock generation steps and reset values.
 * Assumes inclusion by bare name from the design files under src/.
 */
// Overview of operation
// - Pixel bytes of every format pass unchanged; no format configuration exists.
// - With frame-limit option absent the stream is always standard CSI-1.
// - Serial data changes only on falling edges of the forwarded clock.
// - Forwarded clock toggles continuously, blanking included, never gated.
// - Serial data is bytewise, least significant bit first.
// - Serial data idles high whenever no byte is being transferred.
// - Only bytes with frame and line valid are sent; blanking bytes dropped.
// - Each line starts with line start code, first line with frame start.
// - Each line ends with line end code, last line with frame end; here frame end only when frame valid falls together with line valid.
// - Frame start code 0xFF000002 marks a new frame.
// - Frame end code 0xFF000003 closes last line and frame.
// - Codes begin with eight ones, sixteen zeros; never inside pixel data.
// - Eight ones then sixteen zeros forces the completing zero byte to 0x01.
// - Escape detection spans byte boundaries in serial bit order.
// - Parallel data is captured on the falling pixel clock edge.
// - Forwarded clock runs at eight times the pixel clock; one byte per pixel.
// - First line rise in a frame sends frame start, later rises line start.
// - Line fall sends line end; joint fall with frame valid sends frame end.
`ifndef CAMERA_FRAMER_DEFS_VH
`define CAMERA_FRAMER_DEFS_VH

// Code type bytes (fourth byte of each code)
`define LINE_START_CODE     8'h00
`define LINE_END_CODE       8'h01
`define FRAME_START_MARKER  8'h02
`define FRAME_END_MARKER    8'h03
// Leading bytes of every code
`define CODE_LEAD_BYTE      8'hFF
`define CODE_ZERO_BYTE      8'h00
// Byte sent when the line is idle
`define IDLE_BYTE           8'hFF
// Pixel bytes wait this many slots so a start code can go first
`define DATA_DELAY_SLOTS    3'h4
// Half serial clock periods per pixel slot (eight bits, two edges each)
`define HALF_BITS_PER_SLOT  9'h010
// Pixel clock period in system cycles assumed until first measurement
`define RESET_SLOT_PERIOD   8'h14
`define ESCAPED_ZERO        8'h01

`endif

// [src/serial_byte_tx.v]
/*
 * Byte serializer with forwarded clock, derived from the measured pixel
 * slot period: sixteen clock edges are spread evenly across each slot.
 * Assumes a slot period of at least sixteen system cycles.
 */
`include "camera_framer_defs.vh"

module serial_byte_tx (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       slot_tick,
    input  wire [7:0] load_byte,
    output reg        serial_clk,
    output reg        serial_data
);

    reg [7:0] slot_count;
    reg [7:0] slot_period;
    reg [8:0] phase;
    reg [7:0] shift;

    wire [8:0] phase_step = phase + `HALF_BITS_PER_SLOT;
    wire       edge_due   = phase_step >= {1'b0, slot_period};

    always @(posedge clk) begin
        if (!rst_n) begin
            slot_count  <= 8'h00;
            slot_period <= `RESET_SLOT_PERIOD;
            phase       <= 9'h000;
            shift       <= `IDLE_BYTE;
            serial_clk  <= 1'b0;
            serial_data <= 1'b1;
        end else if (slot_tick) begin
            // Realign to the slot: falling edge with bit 0 presented
            slot_count  <= 8'h00;
            // A stalled pixel clock keeps the last measured period
            if (slot_count != 8'hFF)
                slot_period <= slot_count + 8'h01;
            phase       <= 9'h000;
            serial_clk  <= 1'b0;
            shift       <= load_byte;
            serial_data <= load_byte[0];
        end else begin
            if (slot_count != 8'hFF)
                slot_count <= slot_count + 8'h01;
            // Keeps toggling on the last period even without slots
            if (edge_due) begin
                phase      <= phase_step - {1'b0, slot_period};
                serial_clk <= ~serial_clk;
                if (serial_clk) begin
                    // Falling edge: next bit, ones after the byte
                    shift       <= {1'b1, shift[7:1]};
                    serial_data <= shift[1];
                end
            end else begin
                phase <= phase_step;
            end
        end
    end

endmodule // serial_byte_tx

// [verification/camera_serial_framer_monitor.sv]
/* Checker of serial clock rate, serial data timing and idle level of the framer.
   Assumes binding to camera_serial_framer and a pixel clock of constant period. */
module camera_serial_framer_monitor (
    input logic       clk,
    input logic       rst_n,
    input logic       pixel_clock_in,
    input logic       frame_valid,
    input logic       line_valid,
    input logic [7:0] pixel_data,
    input logic       serial_clk,
    input logic       serial_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pc_q;
    logic       sc_q;
    logic [4:0] togs;
    logic [3:0] falls;
    logic [3:0] lv_low;
    logic [3:0] fv_low;
    logic [2:0] gap;
    logic [2:0] warm;
    wire        slot  = pc_q && !pixel_clock_in;
    wire        tog   = serial_clk != sc_q;
    wire        sfall = sc_q && !serial_clk;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Edge counts per pixel slot, blank runs
    // ****************************************
    always @(posedge clk) begin
        pc_q   <= pixel_clock_in;
        sc_q   <= serial_clk;
        gap    <= (tog || !rst_n) ? 3'h0 : gap + 3'h1;
        togs   <= slot ? {4'h0, tog} : togs + {4'h0, tog};
        falls  <= slot ? {3'h0, sfall} : falls + {3'h0, sfall};
        warm   <= !rst_n ? 3'h0 : warm + {2'h0, slot && warm != 3'h7};
        lv_low <= (!rst_n || line_valid) ? 4'h0 : lv_low + {3'h0, slot && lv_low != 4'hF};
        fv_low <= (!rst_n || frame_valid) ? 4'h0 : fv_low + {3'h0, slot && fv_low != 4'hF};
    end
    a_data_on_fall: assert property ($changed(serial_data) |-> $fell(serial_clk))
        else $error("serial data moved away from a clock fall");
    a_held_at_rise: assert property ($rose(serial_clk) |-> $stable(serial_data))
        else $error("serial data moved at a clock rise");
    a_clock_not_gated: assert property (gap < 3'h5)
        else $error("serial clock stood still");
    a_eight_x_rate: assert property (slot && warm == 3'h7 |-> togs == 5'h10)
        else $error("serial clock edges per pixel slot wrong");
    a_byte_per_slot: assert property (slot && warm == 3'h7 |-> falls == 4'h8)
        else $error("serial bits per pixel slot wrong");
    a_line_idle_high: assert property (lv_low >= 4'hC |-> serial_data)
        else $error("serial data low in line blanking");
    a_frame_idle_high: assert property (fv_low >= 4'hC |-> serial_data ##1 serial_data)
        else $error("serial data low in frame blanking");
    a_reset_state: assert property (disable iff (1'b0) !rst_n ##1 !rst_n |-> serial_data && !serial_clk)
        else $error("serial outputs wrong in reset");
endmodule // camera_serial_framer_monitor

// [verification/csi_rx_model.sv]
/* Behavioural serial receiver: locks on sync codes, emits codes and line bytes.
   Assumes the framer's forwarded clock and data pins only. */
module csi_rx_model (
    input  logic        serial_clk,
    input  logic        serial_data,
    output logic [8:0]  rx_word = 9'h000,
    output logic [15:0] rx_count = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sr = 32'h0;
    logic        locked = 1'b0;
    logic        in_line = 1'b0;
    logic [2:0]  nbit = 3'h0;
    logic [7:0]  pend[$];
    // ****************************************
    // Bit sampling and byte framing
    // ****************************************
    always @(posedge serial_clk) begin
        sr = {serial_data, sr[31:1]};
        nbit = nbit + 3'h1;
        if (sr[23:0] == 24'h0000FF && sr[31:26] == 6'h00) begin
            pend.delete();
            in_line = !sr[24];
            rx_word = {1'b1, sr[31:24]};
            rx_count = rx_count + 16'h0001;
            locked = 1'b1;
            nbit = 3'h0;
        end else if (locked && nbit == 3'h0) begin
            pend.push_back(sr[31:24]);
            if (pend.size() > 3) begin
                rx_word = {1'b0, pend.pop_front()};
                rx_count = rx_count + {15'h0000, in_line};
            end
        end
    end
endmodule // csi_rx_model

// [verification/tb_camera_serial_framer.sv]
/* Self-checking bench of camera_serial_framer: drives the camera port, notes
   expected codes and bytes, compares what the receiver model decodes.
   Assumes csi_rx_model and the checker are compiled ahead of it. */
`include "camera_framer_defs.vh"
module tb_camera_serial_framer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pixel_clock_in = 1'b0;
    logic        frame_valid = 1'b0;
    logic        line_valid = 1'b0;
    logic [7:0]  pixel_data = 8'h00;
    wire         serial_clk;
    wire         serial_data;
    wire  [8:0]  rx_word;
    wire  [15:0] rx_count;
    logic [8:0]  exp_q[$];
    logic [8:0]  exp_w;
    logic [7:0]  h1;
    logic [7:0]  h2;
    logic        pfv = 1'b0;
    logic        plv = 1'b0;
    logic        armed = 1'b0;
    logic        in_ln = 1'b0;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    always #2 clk = ~clk;
    camera_serial_framer dut (.clk(clk), .rst_n(rst_n), .pixel_clock_in(pixel_clock_in),
        .frame_valid(frame_valid), .line_valid(line_valid), .pixel_data(pixel_data),
        .serial_clk(serial_clk), .serial_data(serial_data));
    csi_rx_model rx (.serial_clk(serial_clk), .serial_data(serial_data), .rx_word(rx_word),
        .rx_count(rx_count));
    // ****************************************
    // Camera driver and expectations
    // ****************************************
    function automatic logic esc(input logic [7:0] a, input logic [7:0] b);
        esc = 1'b0;
        for (int k = 0; k < 8; k++)
            if (a == 8'((1 << k) - 1) && (b >> k) == (8'hFF >> k)) esc = 1'b1;
    endfunction
    task automatic slot(input logic f, input logic l, input logic [7:0] d);
        @(negedge clk);
        pixel_clock_in = 1'b1;
        {frame_valid, line_valid, pixel_data} = {f, l, d};
        if (f && !pfv) armed = 1'b1;
        if (f && l && !plv) begin
            exp_q.push_back({1'b1, armed ? `FRAME_START_MARKER : `LINE_START_CODE});
            {armed, in_ln, h1, h2} = {2'b01, 16'h0000};
        end else if (in_ln && !l) begin
            exp_q.push_back({1'b1, f ? `LINE_END_CODE : `FRAME_END_MARKER});
            in_ln = 1'b0;
        end
        if (in_ln) begin
            exp_q.push_back({1'b0, (d == 8'h00 && esc(h1, h2)) ? `ESCAPED_ZERO : d});
            {h2, h1} = {h1, exp_q[$][7:0]};
        end
        {pfv, plv} = {f, l};
        repeat (10) @(negedge clk);
        pixel_clock_in = 1'b0;
        repeat (9) @(negedge clk);
    endtask
    task automatic burst(input int n, input logic f, input logic l);
        repeat (n) slot(f, l, 8'($urandom));
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(rx_count) begin
        if (rx_count != 16'h0000) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
            checks_done = checks_done + 1;
            if (rx_word !== exp_w) begin
                errors = errors + 1;
                $display("BAD %0t got %h expected %h", $time, rx_word, exp_w);
            end
        end
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("BAD %0t run took too long", $time);
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(64724));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        burst(4, 1'b0, 1'b0);
        burst(10, 1'b1, 1'b0);
        burst(12, 1'b1, 1'b1);
        burst(10, 1'b1, 1'b0);
        for (int k = 0; k < 8; k++) begin
            slot(1'b1, 1'b1, 8'hFF << k);
            slot(1'b1, 1'b1, 8'((1 << k) - 1));
            slot(1'b1, 1'b1, 8'h00);
            slot(1'b1, 1'b1, 8'h00);
        end
        burst(10, 1'b1, 1'b0);
        burst(8, 1'b1, 1'b1);
        slot(1'b0, 1'b0, 8'h5A);
        burst(12, 1'b0, 1'b0);
        burst(8, 1'b1, 1'b1);
        burst(3, 1'b1, 1'b0);
        burst(12, 1'b0, 1'b0);
        burst(6, 1'b0, 1'b1);
        burst(20, 1'b0, 1'b0);
        checks_done = checks_done + 1;
        if (exp_q.size() != 0) begin
            errors = errors + 1;
            $display("BAD %0t %0d expected items never arrived", $time, exp_q.size());
        end
        report_and_stop();
    end
endmodule // tb_camera_serial_framer
bind camera_serial_framer camera_serial_framer_monitor mon (.clk(clk), .rst_n(rst_n),
    .pixel_clock_in(pixel_clock_in), .frame_valid(frame_valid), .line_valid(line_valid),
    .pixel_data(pixel_data), .serial_clk(serial_clk), .serial_data(serial_data));
